// File: pkg/ccg_pkg.sv
/*
 * ccg_pkg: constants and types for the cpu clock generator.
 * Assumes a single 200 MHz system clock standing in for the oscillator.
 */
package ccg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] CCG_PCCTL_OFFSET = 16'hfffb;
    localparam logic [15:0] CCG_STATUS_OFFSET = 16'hfffc;
    localparam logic [7:0] CCG_PCCTL_RESET = 8'h02;
    localparam int CCG_DIVSEL_BIT = 1;
    // status register field positions
    localparam int CCG_ST_SETTLED_BIT = 0;
    localparam int CCG_ST_DIV_BIT = 1;
    localparam int CCG_ST_STOP_BIT = 2;
    localparam int CCG_ST_HALT_BIT = 3;
    localparam int CCG_ST_SWITCH_BIT = 4;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CCG_SETTLE_CYCLES = 32768;
    localparam int CCG_SLOW_DIV = 4;
    localparam int CCG_SLOW_TO_FAST_MAX = 2;
    localparam int CCG_FAST_TO_SLOW_MAX = 4;
    localparam int CCG_PERIPH_DIV_W = 8;

    typedef enum logic [1:0] {
        CCG_ST_OFF,
        CCG_ST_SETTLE,
        CCG_ST_RUN,
        CCG_ST_STOPPED
    } ccg_state_t;

    // one-cycle clock enables handed to consumers
    typedef struct packed {
        logic cpu_tick;
        logic instr_slot;
        logic [CCG_PERIPH_DIV_W-1:0] periph_ticks;
    } ccg_clk_en_t;
endpackage : ccg_pkg

// File: design/ccg_clock_gen.sv
/*
 * ccg_clock_gen: cpu clock generator with avalon-mm register slave.
 * Assumes clk is the oscillator clock and consumers use the one-cycle
 * enable pulses in clk_en; no derived clock nets are produced.
 */
`timescale 1ns/100ps
module ccg_clock_gen
    import ccg_pkg::*;
#(
    parameter int SETTLE_CYCLES = CCG_SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    input wire logic [7:0] avs_bitmask,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic stop_req,
    input wire logic halt_req,
    input wire logic wake_req,
    output logic osc_enable,
    output logic cpu_run,
    output ccg_clk_en_t clk_en
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [7:0] pcctl;
    logic [7:0] next_pcctl;
    logic [7:0] status;
    logic ack;
    wire hit_ctl = avs_address == CCG_PCCTL_OFFSET;
    wire hit_st = avs_address == CCG_STATUS_OFFSET;
    wire req = avs_read | avs_write;
    wire wr_ctl = avs_write & hit_ctl & ack;
    // one wait state, answer on the second edge of the request
    assign avs_waitrequest = req & ~ack;

    // only bit 1 is implemented; other bits read zero whatever is written
    assign next_pcctl = (pcctl & ~avs_bitmask)
        | (avs_writedata & avs_bitmask);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pcctl <= CCG_PCCTL_RESET;
        end else if (wr_ctl) begin
            pcctl <= next_pcctl & (8'h01 << CCG_DIVSEL_BIT);
        end
    end

    wire [7:0] next_readdata = hit_ctl ? pcctl : (hit_st ? status : 8'h00);

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 8'h00;
        end else if (avs_read & ~ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // oscillator state
    // ------------------------------------------------------------
    ccg_state_t state;
    ccg_state_t next_state;
    logic [15:0] settle_cnt;
    logic halted;
    wire settle_done = settle_cnt == 16'(SETTLE_CYCLES - 1);

    always_comb begin
        next_state = state;
        unique case (state)
            CCG_ST_OFF: next_state = CCG_ST_SETTLE;
            CCG_ST_SETTLE: begin
                if (settle_done) begin
                    next_state = CCG_ST_RUN;
                end
            end
            CCG_ST_RUN: begin
                if (stop_req) begin
                    next_state = CCG_ST_STOPPED;
                end
            end
            CCG_ST_STOPPED: begin
                if (wake_req) begin
                    next_state = CCG_ST_SETTLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= CCG_ST_OFF;
            settle_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            settle_cnt <= (state == CCG_ST_SETTLE) ? settle_cnt + 16'h0001
                : 16'h0000;
        end
    end

    // halt keeps oscillator and peripherals but parks the cpu
    always_ff @(posedge clk) begin
        if (rst) begin
            halted <= 1'b0;
        end else if (wake_req | state != CCG_ST_RUN) begin
            halted <= 1'b0;
        end else if (halt_req) begin
            halted <= 1'b1;
        end
    end

    wire osc_on = ~rst & (state == CCG_ST_SETTLE | state == CCG_ST_RUN);
    wire run = state == CCG_ST_RUN;

    // ------------------------------------------------------------
    // cpu clock with phase-aligned switch
    // ------------------------------------------------------------
    logic [1:0] phase;
    logic div_active;
    logic [2:0] switch_cnt;
    wire div_req = pcctl[CCG_DIVSEL_BIT];
    // the divided clock and fx agree only when the divider wraps, so the
    // selection changes there; worst wait is inside the documented bound
    wire boundary = phase == 2'(CCG_SLOW_DIV - 1);
    wire switching = div_req != div_active;

    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'b00;
            div_active <= 1'b1;
            switch_cnt <= 3'h0;
        end else if (osc_on) begin
            phase <= phase + 2'b01;
            if (switching & boundary) begin
                div_active <= div_req;
            end
            switch_cnt <= switching ? switch_cnt + 3'h1 : 3'h0;
        end
    end

    wire cpu_tick = run & ~halted & (~div_active | boundary);

    // instruction slot: every second cpu tick
    logic slot_half;
    always_ff @(posedge clk) begin
        if (rst) begin
            slot_half <= 1'b0;
        end else if (cpu_tick) begin
            slot_half <= ~slot_half;
        end
    end

    // ------------------------------------------------------------
    // peripheral prescaler
    // ------------------------------------------------------------
    logic [CCG_PERIPH_DIV_W-1:0] pre;
    logic [CCG_PERIPH_DIV_W-1:0] next_pre;
    assign next_pre = pre + CCG_PERIPH_DIV_W'(1);

    always_ff @(posedge clk) begin
        if (rst) begin
            pre <= '0;
        end else if (osc_on) begin
            pre <= next_pre;
        end
    end

    // tick k pulses when bit k of the prescaler rises: fx / 2^(k+1)
    wire [CCG_PERIPH_DIV_W-1:0] rise = next_pre & ~pre;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_en <= '0;
            osc_enable <= 1'b0;
            cpu_run <= 1'b0;
        end else begin
            clk_en.cpu_tick <= cpu_tick;
            clk_en.instr_slot <= cpu_tick & slot_half;
            clk_en.periph_ticks <= osc_on ? rise : '0;
            osc_enable <= osc_on;
            cpu_run <= run & ~halted;
        end
    end

    assign status = {3'b000, switching, halted, state == CCG_ST_STOPPED,
        div_active, run};
endmodule : ccg_clock_gen

// File: dv/ccg_cpu_model.sv
/* Cpu core model: issues standby and wake requests on bench command.
   Assumes cmd is held for one clock: 1 stop, 2 halt, 3 wake. */
`timescale 1ns/100ps
module ccg_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_run,
    input wire logic [1:0] cmd,
    output logic stop_req,
    output logic halt_req,
    output logic wake_req
);
    // ------
    // standby opcodes only execute while running
    // ------
    always_ff @(posedge clk) begin
        stop_req <= !rst && cpu_run && cmd == 2'h1;
        halt_req <= !rst && cpu_run && cmd == 2'h2;
        wake_req <= !rst && cmd == 2'h3;
    end
endmodule : ccg_cpu_model

// File: dv/ccg_clock_gen_monitor.sv
/* Checker on the clock generator ports.
   Assumes the bind passes the shortened settle count. */
`timescale 1ns/100ps
module ccg_clock_gen_monitor
    import ccg_pkg::*;
#(parameter int SETTLE_CYCLES = CCG_SETTLE_CYCLES) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic stop_req,
    input wire logic halt_req,
    input wire logic osc_enable,
    input wire logic cpu_run,
    input wire ccg_clk_en_t clk_en
);
    // ------
    // settle count, first start after reset only
    // ------
    logic [15:0] osc_cnt;
    logic ran;
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_cnt <= '0;
            ran <= 1'b0;
        end else begin
            if (osc_enable) osc_cnt <= osc_cnt + 16'h1;
            if (cpu_run) ran <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_held; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_rd; avs_read && !avs_waitrequest; endsequence
    a_one_wait: assert property (s_held |=> !avs_waitrequest)
        else $error("bus wait too long");
    a_ctl_zeros: assert property (
        s_rd and (avs_address == CCG_PCCTL_OFFSET)
        |-> !(avs_readdata & 8'hfd))
        else $error("ctl reserved bit set");
    a_unmapped_zero: assert property (s_rd and
        (avs_address != CCG_PCCTL_OFFSET &&
        avs_address != CCG_STATUS_OFFSET)
        |-> avs_readdata == 8'h00) else $error("unmapped read not zero");
    a_settle_wait: assert property (
        $rose(cpu_run) && !ran |-> osc_cnt >= SETTLE_CYCLES)
        else $error("cpu ran before settle");
    a_stopped_quiet: assert property (
        !osc_enable [*2] |-> !cpu_run && clk_en == '0)
        else $error("clocks while stopped");
    a_stop_osc: assert property (cpu_run && stop_req
        |-> ##[1:3] !osc_enable) else $error("stop ignored");
    a_halt_cpu: assert property (cpu_run && halt_req
        |-> ##[1:3] !cpu_run && osc_enable) else $error("halt ignored");
    a_periph_div4: assert property (
        clk_en.periph_ticks[1] |=> !clk_en.periph_ticks[1] [*3])
        else $error("periph tick spacing");
endmodule : ccg_clock_gen_monitor
bind ccg_clock_gen ccg_clock_gen_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES))
    u_mon (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .stop_req, .halt_req, .osc_enable, .cpu_run, .clk_en);

// File: dv/testbench.sv
/* Self-checking bench for the clock generator.
   Assumes a 200 MHz clk and a settle count cut to 16. */
`timescale 1ns/100ps
module testbench;
    import ccg_pkg::*;
    localparam int S = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [7:0] avs_writedata = '0;
    logic [7:0] avs_bitmask = '0;
    logic [7:0] avs_readdata, q, d, m;
    logic avs_waitrequest, stop_req, halt_req, wake_req, osc_enable, cpu_run;
    logic [1:0] cmd = '0;
    ccg_clk_en_t clk_en;
    int failures = 0;
    int total_checks = 0;
    int seed = 40199;
    int ref_ctl, n, t, s;
    ccg_clock_gen #(.SETTLE_CYCLES(S)) ccg_clock_gen_inst (.clk, .rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_bitmask,
        .avs_readdata, .avs_waitrequest, .stop_req, .halt_req, .wake_req,
        .osc_enable, .cpu_run, .clk_en);
    ccg_cpu_model ccg_cpu_model_inst (.clk, .rst, .cpu_run, .cmd, .stop_req,
        .halt_req, .wake_req);
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ------
    // tasks
    // ------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %0h want %0h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] a,
        input logic [7:0] dd, input logic [7:0] mm);
        int k;
        k = 0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= dd;
        avs_bitmask <= mm;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) failures++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic ticks(input logic [7:0] c);
        t = 0;
        s = 0;
        repeat (c) begin
            @(posedge clk);
            t += int'(clk_en.cpu_tick === 1'b1);
            s += int'(clk_en.instr_slot === 1'b1);
        end
    endtask : ticks
    task automatic wait_run(input int lim, input logic [1:0] c);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
        n = 0;
        while (cpu_run !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_run
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge clk);
        chk({osc_enable, cpu_run, clk_en}, '0);
        rst <= 1'b0;
        wait_run(S + 40, 2'h0);
        chk(n >= S && n <= S + 5, 1);
        bus(0, CCG_PCCTL_OFFSET, 0, 0);
        chk(q, CCG_PCCTL_RESET);
        ticks(16);
        chk(t + s * 256, 4 + 2 * 256);
        // select fast by clearing bit 1; other bits stay zero
        bus(1, CCG_PCCTL_OFFSET, 8'h00, 8'hff);
        repeat (4) @(posedge clk);
        ticks(16);
        chk(t + s * 256, 16 + 8 * 256);
        bus(1, CCG_PCCTL_OFFSET, 8'h02, 8'h02);
        repeat (4) @(posedge clk);
        ticks(16);
        chk(t, 4);
        ref_ctl = 2;
        repeat (8) begin
            d = 8'($random(seed)) & 8'h02;
            m = 8'h01 << 3'($random(seed));
            bus(1, CCG_PCCTL_OFFSET, d, m);
            if (m[1]) ref_ctl = int'(d);
            bus(0, CCG_PCCTL_OFFSET, 0, 0);
            chk(q, 8'(ref_ctl));
        end
        bus(0, 16'h0000, 0, 0);
        chk(q, 0);
        wait_run(0, 2'h2);
        repeat (4) @(posedge clk);
        chk({osc_enable, cpu_run}, 2'b10);
        wait_run(10, 2'h3);
        chk(cpu_run, 1);
        wait_run(0, 2'h1);
        repeat (4) @(posedge clk);
        chk({osc_enable, cpu_run, clk_en}, '0);
        wait_run(S + 40, 2'h3);
        chk(cpu_run, 1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk({osc_enable, cpu_run, clk_en}, '0);
        rst <= 1'b0;
        bus(0, CCG_PCCTL_OFFSET, 0, 0);
        chk(q, CCG_PCCTL_RESET);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule : testbench
